// >>> hdl/spcg_top.sv
// file: sleep-mode peripheral clock gating registers with wishbone slave
`timescale 1ns/1ps
module spcg_top
    import spcg_pkg::*;
(
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    input  wire logic                        we_i,
    input  wire logic [SPCG_AW-1:0]          adr_i,
    input  wire logic [3:0]                  sel_i,
    input  wire logic [31:0]                 dat_i,
    input  wire logic                        sleep_i,
    input  wire logic [SPCG_NPERIPH-1:0]     periph_run_en_i,
    input  wire logic [SPCG_NPORT-1:0]       port_run_en_i,
    output logic      [31:0]                 dat_o,
    output logic                             ack_o,
    output logic      [SPCG_NPERIPH-1:0]     periph_clk_en_o,
    output logic      [SPCG_NPORT-1:0]       port_clk_en_o
);
    spcg_bus_e    bus_reg;
    spcg_bus_e    bus_next;
    logic [31:0]  dat_reg;
    logic [31:0]  dat_next;
    logic [31:0]  apb_q;
    logic [31:0]  ahb_q;
    logic         req;
    logic         ack_reg;
    logic         hit_apb;
    logic         hit_ahb;
    logic         hit_stat;
    logic [31:0]  stat_word;
    logic [SPCG_NPERIPH-1:0] periph_keep;
    logic [SPCG_NPORT-1:0]   port_keep;
    logic [SPCG_NPERIPH-1:0] periph_en_w;
    logic [SPCG_NPORT-1:0]   port_en_w;

    // new request taken only while idle, so each access acks exactly once
    assign req      = cyc_i & stb_i & (bus_reg == SPCG_IDLE);
    assign hit_apb  = (adr_i == SPCG_APB_OFFSET);
    assign hit_ahb  = (adr_i == SPCG_AHB_OFFSET);
    assign hit_stat = (adr_i == SPCG_STAT_OFFSET);

    // the two control registers
    spcg_regbit #(
        .MASK (SPCG_APB_MASK)
    ) u_apb (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (req & we_i & hit_apb),
        .sel_i   (sel_i),
        .wdata_i (dat_i),
        .q_o     (apb_q)
    );

    spcg_regbit #(
        .MASK (SPCG_AHB_MASK)
    ) u_ahb (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (req & we_i & hit_ahb),
        .sel_i   (sel_i),
        .wdata_i (dat_i),
        .q_o     (ahb_q)
    );

    // field extraction toward the peripheral gates
    assign periph_keep[11] = apb_q[SPCG_BIT_COMP];
    assign periph_keep[10] = apb_q[SPCG_BIT_ADC];
    assign periph_keep[9]  = apb_q[SPCG_BIT_TIM2];
    assign periph_keep[8]  = apb_q[SPCG_BIT_TIM1];
    assign periph_keep[7]  = apb_q[SPCG_BIT_TIM0];
    assign periph_keep[6]  = apb_q[SPCG_BIT_PWM];
    assign periph_keep[5]  = apb_q[SPCG_BIT_WDOG];
    assign periph_keep[4]  = apb_q[SPCG_BIT_RTC];
    assign periph_keep[3]  = apb_q[SPCG_BIT_I2C];
    assign periph_keep[2]  = apb_q[SPCG_BIT_SPI];
    assign periph_keep[1]  = apb_q[SPCG_BIT_SER1];
    assign periph_keep[0]  = apb_q[SPCG_BIT_SER0];
    assign port_keep       = ahb_q[SPCG_NPORT-1:0];

    // enables as gated now, readable for status
    spcg_gate_out #(
        .N (SPCG_NPERIPH)
    ) u_pgate (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sleep_i  (sleep_i),
        .run_en_i (periph_run_en_i),
        .keep_i   (periph_keep),
        .clk_en_o (periph_en_w)
    );

    spcg_gate_out #(
        .N (SPCG_NPORT)
    ) u_qgate (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sleep_i  (sleep_i),
        .run_en_i (port_run_en_i),
        .keep_i   (port_keep),
        .clk_en_o (port_en_w)
    );

    assign periph_clk_en_o = periph_en_w;
    assign port_clk_en_o   = port_en_w;

    // status word: live enables and sleep flag
    assign stat_word = {11'h000, sleep_i, port_en_w, 4'h0, periph_en_w};

    // read mux; unmapped addresses read zero and still ack
    assign dat_next = !req      ? dat_reg :
                      hit_apb   ? apb_q   :
                      hit_ahb   ? ahb_q   :
                      hit_stat  ? stat_word :
                                  32'h0000_0000;

    // one wait state: ack the cycle after the request, drop it the next
    always_comb begin
        bus_next = bus_reg;
        unique case (bus_reg)
            SPCG_IDLE: if (req) begin
                bus_next = SPCG_ACK;
            end
            SPCG_ACK: bus_next = SPCG_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_reg <= SPCG_IDLE;
            dat_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
        end else begin
            bus_reg <= bus_next;
            dat_reg <= dat_next;
            ack_reg <= (bus_next == SPCG_ACK); // ack straight from its own flop
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;
endmodule : spcg_top

// >>> hdl/spcg_pkg.sv
// package: register map, field positions, reset values and enums of the sleep clock gating block
// Contract
// - apb bit 26 gates comparator clock in sleep
// - apb bit 24 gates converter clock in sleep
// - apb bits 18..16 gate timers two..zero
// - apb bit 12 gates pwm zero clock
// - apb bit 11 gates watchdog clock in sleep
// - apb bit 10 gates real-time clock in sleep
// - apb bit 6 gates i2c zero clock
// - apb bit 4 gates spi zero clock
// - apb bits 1,0 gate serial ports one, zero
// - ahb bits 3..0 gate ports d..a
// - unassigned bits read zero, writes ignored
// - all control bits reset zero, always read-write
package spcg_pkg;
    localparam int unsigned         SPCG_AW          = 8;
    localparam logic [SPCG_AW-1:0]  SPCG_APB_OFFSET  = 8'h50;
    localparam logic [SPCG_AW-1:0]  SPCG_AHB_OFFSET  = 8'h54;
    localparam logic [SPCG_AW-1:0]  SPCG_STAT_OFFSET = 8'h60;
    // apb register field positions
    localparam int unsigned         SPCG_BIT_COMP    = 26;
    localparam int unsigned         SPCG_BIT_ADC     = 24;
    localparam int unsigned         SPCG_BIT_TIM2    = 18;
    localparam int unsigned         SPCG_BIT_TIM1    = 17;
    localparam int unsigned         SPCG_BIT_TIM0    = 16;
    localparam int unsigned         SPCG_BIT_PWM     = 12;
    localparam int unsigned         SPCG_BIT_WDOG    = 11;
    localparam int unsigned         SPCG_BIT_RTC     = 10;
    localparam int unsigned         SPCG_BIT_I2C     = 6;
    localparam int unsigned         SPCG_BIT_SPI     = 4;
    localparam int unsigned         SPCG_BIT_SER1    = 1;
    localparam int unsigned         SPCG_BIT_SER0    = 0;
    localparam int unsigned         SPCG_NPERIPH     = 12;
    localparam int unsigned         SPCG_NPORT       = 4;
    // writable masks: everything else is read-only zero
    localparam logic [31:0]         SPCG_APB_MASK    = 32'h0507_1c53;
    localparam logic [31:0]         SPCG_AHB_MASK    = 32'h0000_000f;
    localparam logic [31:0]         SPCG_RESET_VAL   = 32'h0000_0000;
    // bus answer states, gray along idle -> ack
    typedef enum logic [0:0] {
        SPCG_IDLE = 1'b0,
        SPCG_ACK  = 1'b1
    } spcg_bus_e;
endpackage : spcg_pkg

// >>> hdl/spcg_regbit.sv
// file: one masked 32-bit control register with synchronous reset
`timescale 1ns/1ps
module spcg_regbit
    import spcg_pkg::*;
#(
    parameter logic [31:0] MASK = 32'h0000_0000
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] wdata_i,
    output logic      [31:0] q_o
);
    logic [31:0] q_reg;
    logic [31:0] q_next;
    logic [31:0] lane_mask;

    // byte enables widened to a bit mask
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign lane_mask[g*8 +: 8] = {8{sel_i[g]}};
        end
    endgenerate

    // unassigned positions never store a value
    assign q_next = we_i ? (((q_reg & ~lane_mask) | (wdata_i & lane_mask)) & MASK)
                         : q_reg;

    // storage, cleared by reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg <= SPCG_RESET_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule : spcg_regbit

// >>> hdl/spcg_gate_out.sv
// file: per-line clock enable stage applying sleep gating
`timescale 1ns/1ps
module spcg_gate_out #(
    parameter int unsigned N = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         sleep_i,
    input  wire logic [N-1:0] run_en_i,
    input  wire logic [N-1:0] keep_i,
    output logic      [N-1:0] clk_en_o
);
    logic [N-1:0] en_reg;
    logic [N-1:0] en_next;

    // in run mode follow ordinary enable; in sleep a set bit keeps the clock
    assign en_next = sleep_i ? (run_en_i & keep_i) : run_en_i;

    // registered enable feeds the glitch-free gate cell
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg <= '0;
        end else begin
            en_reg <= en_next;
        end
    end

    assign clk_en_o = en_reg;
endmodule : spcg_gate_out

// >>> tb/spcg_checker.sv
// checker: bus handshake, reserved bits and gated enables of the sleep gating block
`timescale 1ns/1ps
module spcg_checker
    import spcg_pkg::*;
(
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    cyc_i,
    input wire logic                    stb_i,
    input wire logic                    we_i,
    input wire logic [SPCG_AW-1:0]      adr_i,
    input wire logic [3:0]              sel_i,
    input wire logic [31:0]             dat_i,
    input wire logic                    sleep_i,
    input wire logic [SPCG_NPERIPH-1:0] periph_run_en_i,
    input wire logic [SPCG_NPORT-1:0]   port_run_en_i,
    input wire logic [31:0]             dat_o,
    input wire logic                    ack_o,
    input wire logic [SPCG_NPERIPH-1:0] periph_clk_en_o,
    input wire logic [SPCG_NPORT-1:0]   port_clk_en_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // a request the idle slave takes at this edge
    wire logic req = cyc_i & stb_i & ~ack_o;
    wire logic hole = !(adr_i inside {SPCG_APB_OFFSET, SPCG_AHB_OFFSET, SPCG_STAT_OFFSET});
    AST_ACK_NEXT: assert property (req |=> ack_o) else $error("ack late");
    AST_ACK_ONE: assert property (ack_o |=> !ack_o) else $error("ack stuck");
    AST_ACK_CAUSE: assert property (ack_o |-> $past(req)) else $error("ack unasked");
    AST_RUN_PER: assert property (!sleep_i |=>
        periph_clk_en_o == $past(periph_run_en_i)) else $error("run enable lost");
    AST_RUN_PORT: assert property (!sleep_i |=>
        port_clk_en_o == $past(port_run_en_i)) else $error("port enable lost");
    AST_SLEEP_CUT: assert property (sleep_i |=>
        (periph_clk_en_o & ~$past(periph_run_en_i)) == '0) else $error("sleep adds enable");
    AST_APB_RSV: assert property (ack_o && adr_i == SPCG_APB_OFFSET |->
        (dat_o & ~SPCG_APB_MASK) == 0) else $error("apb reserved set");
    AST_AHB_RSV: assert property (ack_o && adr_i == SPCG_AHB_OFFSET |->
        (dat_o & ~SPCG_AHB_MASK) == 0) else $error("ahb reserved set");
    AST_HOLE: assert property (ack_o && hole |-> dat_o == 32'h0)
        else $error("hole reads data");
endmodule : spcg_checker
bind spcg_top spcg_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .sleep_i(sleep_i),
    .periph_run_en_i(periph_run_en_i), .port_run_en_i(port_run_en_i), .dat_o(dat_o),
    .ack_o(ack_o), .periph_clk_en_o(periph_clk_en_o), .port_clk_en_o(port_clk_en_o));

// >>> tb/testbench.sv
// testbench: random bus traffic and sleep gating against a reference model
`timescale 1ns/1ps
module testbench;
    import spcg_pkg::*;
    logic clk_i, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sleep_i = 0, ack_o, w;
    logic [7:0] adr_i = 0, a;
    logic [3:0] sel_i = 0, port_run_en_i = 0, port_clk_en_o, po;
    logic [31:0] dat_i = 0, dat_o, apb_m = 0, ahb_m = 0, st_m = 0, q, ex, bm;
    logic [11:0] periph_run_en_i = 0, periph_clk_en_o, pe;
    int bad_count = 0, n_compared = 0;
    int pos[12] = '{0, 1, 4, 6, 10, 11, 12, 16, 17, 18, 24, 26};
    spcg_top i_spcg_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .sleep_i(sleep_i),
        .periph_run_en_i(periph_run_en_i), .port_run_en_i(port_run_en_i), .dat_o(dat_o),
        .ack_o(ack_o), .periph_clk_en_o(periph_clk_en_o), .port_clk_en_o(port_clk_en_o));
    // 10 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // one classic cycle; answer always holds the value before any write
    task automatic wb(input logic wr, input logic [7:0] ad, input logic [3:0] s,
                      input logic [31:0] wd);
        int n;
        n = 0;
        ex = (ad == SPCG_APB_OFFSET) ? apb_m : (ad == SPCG_AHB_OFFSET) ? ahb_m :
             (ad == SPCG_STAT_OFFSET) ? st_m : 32'h0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= ad;
        sel_i <= s;
        dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        check("ack delay", n, 2);
        check("rd", q, ex);
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        if (wr && ad == SPCG_APB_OFFSET) apb_m = (apb_m & ~bm | wd & bm) & SPCG_APB_MASK;
        if (wr && ad == SPCG_AHB_OFFSET) ahb_m = (ahb_m & ~bm | wd & bm) & SPCG_AHB_MASK;
        @(posedge clk_i);
    endtask : wb
    // enables land one edge after the inputs change
    task automatic gate_chk();
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 12; i++) pe[i] = periph_run_en_i[i] & (!sleep_i | apb_m[pos[i]]);
        po = port_run_en_i & (sleep_i ? ahb_m[3:0] : 4'hf);
        st_m = {11'h000, sleep_i, po, 4'h0, pe};
        check("pe", 32'(periph_clk_en_o), 32'(pe));
        check("po", 32'(port_clk_en_o), 32'(po));
    endtask : gate_chk
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    // main sequence: reset, full-ones writes, then random traffic
    initial begin
        void'($urandom(40));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, SPCG_APB_OFFSET, 4'hf, 32'h0);
        wb(1'b0, SPCG_AHB_OFFSET, 4'hf, 32'h0);
        wb(1'b1, SPCG_APB_OFFSET, 4'hf, 32'hffff_ffff);
        wb(1'b1, SPCG_AHB_OFFSET, 4'hf, 32'hffff_ffff);
        repeat (60) begin
            w = 1'($urandom);
            a = 8'h50 + 8'(4 * $urandom_range(0, 2));
            wb(w, a, 4'($urandom), $urandom);
            sleep_i <= 1'($urandom);
            periph_run_en_i <= 12'($urandom);
            port_run_en_i <= 4'($urandom);
            gate_chk();
            wb(1'($urandom), SPCG_STAT_OFFSET, 4'hf, $urandom);
        end
        stop_test();
    end
    // watchdog against a hung handshake
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
endmodule : testbench
